/* File: eeprom_cmd_pkg.sv */
// constants and types shared by the serial eeprom command unit
package eeprom_cmd_pkg;

  // opcodes seen on the serial input
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;

  // rising-edge counter values, counted from 0 at the first rise
  localparam logic [5:0] CNT_LATCH = 6'h07;
  localparam logic [5:0] CNT_OPC_LAST = 6'h07;
  localparam logic [5:0] CNT_ADDR_FIRST = 6'h08;
  localparam logic [5:0] CNT_ADDR_LAST = 6'h17;
  localparam logic [5:0] CNT_STS_ARM = 6'h0f;
  localparam logic [5:0] CNT_STS_OUT = 6'h08;
  localparam logic [5:0] CNT_READ_OUT = 6'h18;
  localparam logic [5:0] CNT_DATA_END = 6'h1f;
  localparam logic [5:0] CNT_WRAP_LO = 6'h20;
  localparam logic [5:0] CNT_WRAP_HI = 6'h27;

  // block-protect encodings
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_QUARTER = 2'h1;
  localparam logic [1:0] GUARD_HALF = 2'h2;
  localparam logic [1:0] GUARD_ALL = 2'h3;

  // sizes and timing
  localparam int ADDR_W_DEF = 12;
  localparam int PAGE_BYTES_DEF = 32;
  localparam int HOST_ADDR_BITS = 16;
  localparam int CLK_KHZ = 20000;
  localparam int WRITE_CYCLE_TIME_MS = 5;
  localparam int WRITE_CYCLES_DEF = WRITE_CYCLE_TIME_MS * CLK_KHZ;

  // values after reset
  localparam logic NV_BIT_RST = 1'b0;
  localparam logic [5:0] SYNC_RST = 6'h03;

  // crossing vector bit positions (mclk side)
  localparam int SY_CS = 0;
  localparam int SY_WP = 1;
  localparam int SY_ARR = 2;
  localparam int SY_STS = 3;
  localparam int SY_SET = 4;
  localparam int SY_CLR = 5;

  typedef struct packed {
    logic pin_gate_enable;
    logic [2:0] zero;
    logic block_guard_hi;
    logic block_guard_lo;
    logic write_latch;
    logic write_busy;
  } status_word_t;

endpackage

/* File: serial_eeprom_command_unit.sv */
// serial eeprom command unit: decoder, status word, array and write timer
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R1: status write changes only bits 7,3,2
// R2: pin gate bit enables write-protect pin
// R3: bit 1 shows the write latch
// R4: bit 0 shows write busy
// R5: guard pair selects protected region
// R6: protected array writes dropped, reads normal
// R7: protect pin blocks only status writes
// R8: fixed eight-bit opcode codes
// R9: latch commands act on clock 7 rise
// R10: writes need latch; finished write clears it
// R11: read data from 24th fall, msb first
// R12: read address increments and wraps
// R13: write starts only at byte-end select rise
// R14: write cycle 5 ms, only status read
// R15: page write wraps within page
// R16: status write armed after data bit 0
// R17: protect pin low cancels pending status write
// R18: pause freezes transfer, floats output
// R19: select rise during pause resets command
// R20: reads end on select rise, no effect
// R21: array write cancel before bit 0
// R22: host raises select with clock low
// R23: sample on rise, shift on fall
// R24: guard bits nonvolatile, latch volatile
// R25: status read repeats status byte
module serial_eeprom_command_unit
  import eeprom_cmd_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int PAGE_BYTES = PAGE_BYTES_DEF,
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  // core clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // serial link
  input wire logic spi_clk_i,
  input wire logic chip_select_n_i,
  input wire logic serial_in_i,
  input wire logic transfer_pause_n_i,
  input wire logic write_protect_n_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  // status
  output logic write_busy_o
);

  localparam int PG_W = $clog2(PAGE_BYTES);
  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam int DEPTH = 2 ** ADDR_W;

  // refuse shapes the logic cannot serve
  initial begin
    if (ADDR_W < 3 || ADDR_W > HOST_ADDR_BITS ||
        PAGE_BYTES < 4 || (2 ** PG_W) != PAGE_BYTES ||
        PG_W >= ADDR_W || WRITE_CYCLES < PAGE_BYTES + 2) begin
      $error("serial_eeprom_command_unit: bad parameters");
    end
  end

  typedef enum logic [1:0] {W_IDLE, W_ARRAY, W_TIMED} wstate_t;

  // array storage, written by the core, read by the link while idle
  logic [7:0] mem [0:DEPTH-1];

  // link-side state
  logic link_rst_n;
  logic live;
  logic [5:0] cnt_q;
  logic [6:0] sr_q;
  logic [7:0] op_q;
  logic [7:0] shift_in;
  logic byte_end;
  logic [HOST_ADDR_BITS-1:0] addr_q;
  logic [HOST_ADDR_BITS-1:0] addr_next;
  logic [PG_W-1:0] pg_ptr_q;
  logic [7:0] page_buf [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] vld_q;
  logic [6:0] sts_new_q;
  logic arr_armed_q;
  logic sts_armed_q;
  logic set_tog_q;
  logic clr_tog_q;
  status_word_t st_meta_q;
  status_word_t st_sync_q;
  logic [ADDR_W-1:0] rd_ptr_q;
  logic [7:0] out_sh_q;
  logic so_q;
  logic oe_q;

  // core-side state
  logic [5:0] sy_meta_q;
  logic [5:0] sy_q;
  logic [5:0] sy_prev_q;
  logic frame_end;
  logic set_ev;
  logic clr_ev;
  logic wp_low_seen_q;
  logic consumed_q;
  logic launch_arr;
  logic launch_sts;
  wstate_t wstate_q;
  logic [PG_W-1:0] idx_q;
  logic [TW-1:0] timer_q;
  logic busy_q;
  logic latch_q;
  logic pin_gate_enable_q;
  logic block_guard_hi_q;
  logic block_guard_lo_q;
  logic wr_done;
  logic [ADDR_W-1:0] wr_addr;
  status_word_t status_word;

  // protected-region test on the top address bits
  function automatic logic guarded(input logic [ADDR_W-1:0] a,
                                   input logic [1:0] g);
    logic r;
    r = 1'b0;
    case (g)
      GUARD_QUARTER: r = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
      GUARD_HALF: r = a[ADDR_W-1];
      GUARD_ALL: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r; // R5
  endfunction

  // ---------------- link clock domain ----------------

  // select high clears the frame; pause stops the clock from counting
  assign link_rst_n = rst_b_i & ~chip_select_n_i; // R19 R20
  assign live = transfer_pause_n_i; // R18
  assign shift_in = {sr_q, serial_in_i}; // R23
  assign addr_next = {addr_q[HOST_ADDR_BITS-2:0], serial_in_i};
  assign byte_end = (cnt_q >= CNT_DATA_END) && (cnt_q[2:0] == 3'h7);

  // bit counter, shifter and opcode; lost whenever select rises
  always_ff @(posedge spi_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_q <= 6'h00;
      sr_q <= 7'h00;
      op_q <= OP_NONE;
    end else if (live) begin
      cnt_q <= (cnt_q == CNT_WRAP_HI) ? CNT_WRAP_LO : cnt_q + 6'h01;
      sr_q <= shift_in[6:0]; // R23
      if (cnt_q == CNT_OPC_LAST) begin
        // only status read gets through a running write cycle
        if (st_sync_q.write_busy && shift_in != OP_STATUS_READ) begin
          op_q <= OP_NONE; // R14
        end else begin
          op_q <= shift_in; // R8
        end
      end
    end
  end

  // frame results that must outlive the select rise for the core
  always_ff @(posedge spi_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_q <= '0;
      pg_ptr_q <= '0;
      vld_q <= '0;
      sts_new_q <= 7'h00;
      arr_armed_q <= 1'b0;
      sts_armed_q <= 1'b0;
    end else if (live && !chip_select_n_i) begin
      // armed only in the gap after the last data bit
      arr_armed_q <= (op_q == OP_ARRAY_WRITE) && byte_end; // R13 R21
      sts_armed_q <= (op_q == OP_STATUS_WRITE) &&
                     (cnt_q == CNT_STS_ARM); // R16
      // status reads may run mid-commit, so they must not touch the address
      if ((op_q == OP_ARRAY_READ || op_q == OP_ARRAY_WRITE) &&
          cnt_q >= CNT_ADDR_FIRST && cnt_q <= CNT_ADDR_LAST) begin
        addr_q <= addr_next; // R23
      end
      if (cnt_q == CNT_ADDR_LAST) begin
        pg_ptr_q <= addr_next[PG_W-1:0];
      end
      if (cnt_q == CNT_OPC_LAST && shift_in == OP_ARRAY_WRITE &&
          !st_sync_q.write_busy) begin
        vld_q <= '0;
      end else if (op_q == OP_ARRAY_WRITE && byte_end) begin
        vld_q[pg_ptr_q] <= 1'b1;
        pg_ptr_q <= pg_ptr_q + 1'b1; // R15
      end
      if (op_q == OP_STATUS_WRITE && cnt_q == CNT_STS_ARM) begin
        sts_new_q <= shift_in[7:1];
      end
    end
  end

  // page buffer; later bytes overwrite earlier ones after a wrap
  always_ff @(posedge spi_clk_i) begin
    if (live && !chip_select_n_i && op_q == OP_ARRAY_WRITE && byte_end) begin
      page_buf[pg_ptr_q] <= shift_in; // R15
    end
  end

  // latch commands leave as toggles, decided on the last opcode bit
  always_ff @(posedge spi_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      set_tog_q <= 1'b0;
      clr_tog_q <= 1'b0;
    end else if (live && !chip_select_n_i && cnt_q == CNT_LATCH &&
                 !st_sync_q.write_busy) begin
      if (shift_in == OP_LATCH_SET) begin
        set_tog_q <= ~set_tog_q; // R9
      end
      if (shift_in == OP_LATCH_CLEAR) begin
        clr_tog_q <= ~clr_tog_q; // R9
      end
    end
  end

  // status word into the link domain; flushed by the opcode clocks
  always_ff @(posedge spi_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_meta_q <= '0;
      st_sync_q <= '0;
    end else begin
      st_meta_q <= status_word;
      st_sync_q <= st_meta_q;
    end
  end

  // output shifter on the falling edge
  always_ff @(negedge spi_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      out_sh_q <= 8'h00;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      rd_ptr_q <= '0;
    end else if (live) begin
      if (op_q == OP_ARRAY_READ && cnt_q >= CNT_READ_OUT &&
          cnt_q[2:0] == 3'h0) begin
        // new byte; the first comes from the received address
        if (cnt_q == CNT_READ_OUT) begin
          out_sh_q <= {mem[addr_q[ADDR_W-1:0]][6:0], 1'b0};
          so_q <= mem[addr_q[ADDR_W-1:0]][7]; // R11
          rd_ptr_q <= addr_q[ADDR_W-1:0] + 1'b1;
        end else begin
          out_sh_q <= {mem[rd_ptr_q][6:0], 1'b0};
          so_q <= mem[rd_ptr_q][7];
          rd_ptr_q <= rd_ptr_q + 1'b1; // R12
        end
        oe_q <= 1'b1;
      end else if (op_q == OP_STATUS_READ && cnt_q >= CNT_STS_OUT &&
                   cnt_q[2:0] == 3'h0) begin
        out_sh_q <= {st_sync_q[6:0], 1'b0};
        so_q <= st_sync_q[7]; // R25
        oe_q <= 1'b1;
      end else begin
        out_sh_q <= {out_sh_q[6:0], 1'b0};
        so_q <= out_sh_q[7]; // R23
      end
    end
  end

  // pause must float the pin at once, so the enable is gated here
  assign serial_out_o = so_q;
  assign serial_out_oe_o = oe_q & transfer_pause_n_i; // R18

  // ---------------- core clock domain ----------------

  // two-stage synchronisers for select, protect pin and link results
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sy_meta_q <= SYNC_RST;
      sy_q <= SYNC_RST;
      sy_prev_q <= SYNC_RST;
    end else begin
      sy_meta_q <= {clr_tog_q, set_tog_q, sts_armed_q, arr_armed_q,
                    write_protect_n_i, chip_select_n_i};
      sy_q <= sy_meta_q;
      sy_prev_q <= sy_q;
    end
  end

  assign frame_end = sy_q[SY_CS] & ~sy_prev_q[SY_CS];
  assign set_ev = sy_q[SY_SET] ^ sy_prev_q[SY_SET];
  assign clr_ev = sy_q[SY_CLR] ^ sy_prev_q[SY_CLR];

  // launch on select rise, only from an armed gap with the latch set
  assign launch_arr = frame_end && sy_q[SY_ARR] && latch_q &&
                      !busy_q && !consumed_q; // R10 R13 R21
  assign launch_sts = frame_end && sy_q[SY_STS] && latch_q &&
                      !busy_q && !consumed_q &&
                      !(pin_gate_enable_q &&
                        (wp_low_seen_q || !sy_q[SY_WP])); // R7 R17 R2

  // protect pin watch across the whole frame, ignored once writing
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_low_seen_q <= 1'b0;
    end else if (frame_end) begin
      wp_low_seen_q <= 1'b0;
    end else if (!sy_q[SY_CS] && !sy_q[SY_WP]) begin
      wp_low_seen_q <= 1'b1; // R17
    end
  end

  // an armed level that outlives its frame must not launch twice
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      consumed_q <= 1'b0;
    end else if (launch_arr || launch_sts) begin
      consumed_q <= 1'b1;
    end else if (!sy_q[SY_ARR] && !sy_q[SY_STS]) begin
      consumed_q <= 1'b0;
    end
  end

  assign wr_done = busy_q && (timer_q == TW'(WRITE_CYCLES - 1));
  assign wr_addr = {addr_q[ADDR_W-1:PG_W], idx_q};

  // write cycle sequencer and its fixed-length timer
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wstate_q <= W_IDLE;
      idx_q <= '0;
      timer_q <= '0;
      busy_q <= 1'b0;
    end else begin
      case (wstate_q)
        W_IDLE: begin
          timer_q <= '0;
          idx_q <= '0;
          if (launch_arr) begin
            wstate_q <= W_ARRAY;
            busy_q <= 1'b1; // R4
          end else if (launch_sts) begin
            wstate_q <= W_TIMED;
            busy_q <= 1'b1; // R4
          end
        end
        W_ARRAY: begin
          timer_q <= timer_q + 1'b1;
          idx_q <= idx_q + 1'b1;
          if (idx_q == PG_W'(PAGE_BYTES - 1)) begin
            wstate_q <= W_TIMED;
          end
        end
        W_TIMED: begin
          timer_q <= timer_q + 1'b1;
          if (wr_done) begin
            wstate_q <= W_IDLE;
            busy_q <= 1'b0; // R14
          end
        end
        default: begin
          wstate_q <= W_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // page commit, one byte a cycle, skipping guarded addresses
  always_ff @(posedge mclk_i) begin
    if (wstate_q == W_ARRAY && vld_q[idx_q] &&
        !guarded(wr_addr, {block_guard_hi_q, block_guard_lo_q})) begin
      mem[wr_addr] <= page_buf[idx_q]; // R6
    end
  end

  // write latch: commands ignored while busy, cleared by a finished write
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_q <= 1'b0; // R24
    end else if (set_ev && !busy_q) begin
      latch_q <= 1'b1; // R9
    end else if (clr_ev && !busy_q) begin
      latch_q <= 1'b0; // R9
    end else if (wr_done) begin
      latch_q <= 1'b0; // R10
    end
  end

  // nonvolatile bits; reset stands in for the shipped contents
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_gate_enable_q <= NV_BIT_RST;
      block_guard_hi_q <= NV_BIT_RST;
      block_guard_lo_q <= NV_BIT_RST;
    end else if (launch_sts) begin
      pin_gate_enable_q <= sts_new_q[6]; // R1 R24
      block_guard_hi_q <= sts_new_q[2]; // R1
      block_guard_lo_q <= sts_new_q[1]; // R1
    end
  end

  // status word as the host reads it
  always_comb begin
    status_word.pin_gate_enable = pin_gate_enable_q;
    status_word.zero = 3'h0; // R1
    status_word.block_guard_hi = block_guard_hi_q;
    status_word.block_guard_lo = block_guard_lo_q;
    status_word.write_latch = latch_q; // R3
    status_word.write_busy = busy_q; // R4
  end

  assign write_busy_o = busy_q;

endmodule

`default_nettype wire

/* File: eeprom_cmd_checker.sv */
// port assertions for the serial eeprom command unit
`timescale 1ns/100ps
`default_nettype none
module eeprom_cmd_checker
  import eeprom_cmd_pkg::*;
#(
  parameter int WRITE_CYCLES = 64
) (
  // core side
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic write_busy_o,
  // serial link
  input wire logic spi_clk_i,
  input wire logic chip_select_n_i,
  input wire logic serial_in_i,
  input wire logic transfer_pause_n_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o
);
  int unsigned bcnt_q;
  int unsigned cnt_q;
  logic [7:0] op_q;

  // length of the current busy stretch
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bcnt_q <= 0;
    end else begin
      bcnt_q <= write_busy_o ? bcnt_q + 1 : 0;
    end
  end

  // rises of this frame; paused rises are not counted
  always_ff @(posedge spi_clk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      cnt_q <= 0;
    end else if (transfer_pause_n_i) begin
      cnt_q <= cnt_q + 1;
    end
  end

  // opcode as the device should take it, msb first
  always_ff @(posedge spi_clk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      op_q <= 8'h00;
    end else if (transfer_pause_n_i && cnt_q < 8) begin
      op_q <= {op_q[6:0], serial_in_i};
    end
  end

  chk_pause_float: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i) !transfer_pause_n_i |-> !serial_out_oe_o)
    else $error("output driven while paused");
  chk_desel_float: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i) chip_select_n_i |-> !serial_out_oe_o)
    else $error("output driven while deselected");
  chk_busy_len: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i) $fell(write_busy_o)
    |-> bcnt_q inside {[WRITE_CYCLES - 6:WRITE_CYCLES]})
    else $error("write cycle length wrong");
  chk_busy_launch: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i) $rose(write_busy_o) |-> $past(chip_select_n_i))
    else $error("write began inside a frame");
  chk_out_early: assert property (@(posedge spi_clk_i)
    disable iff (chip_select_n_i) serial_out_oe_o |-> cnt_q >= 8)
    else $error("output driven during opcode");
  chk_read_drive: assert property (@(posedge spi_clk_i)
    disable iff (chip_select_n_i) transfer_pause_n_i && !write_busy_o
    && op_q == OP_ARRAY_READ && cnt_q == 24 |-> serial_out_oe_o)
    else $error("read data not driven");
  chk_stat_drive: assert property (@(posedge spi_clk_i)
    disable iff (chip_select_n_i) transfer_pause_n_i
    && op_q == OP_STATUS_READ && cnt_q == 8 |-> serial_out_oe_o)
    else $error("status not driven");
  chk_stat_zero: assert property (@(posedge spi_clk_i)
    disable iff (chip_select_n_i) transfer_pause_n_i
    && op_q == OP_STATUS_READ && cnt_q > 8 && (cnt_q % 8) inside {[1:3]}
    |-> serial_out_oe_o && !serial_out_o)
    else $error("status bits 6 to 4 not zero");

  cov_write: cover property (@(posedge mclk_i) $rose(write_busy_o));
  cov_status: cover property (@(posedge spi_clk_i)
    op_q == OP_STATUS_READ && cnt_q == 16);
  cov_read: cover property (@(posedge spi_clk_i)
    op_q == OP_ARRAY_READ && cnt_q == 40 && serial_out_oe_o);
endmodule
`default_nettype wire

/* File: spi_host_model.sv */
// mode 0 host that drives the serial link of the command unit
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  // link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  output logic hold_n_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  logic [7:0] rx_q;
  event rx_ev;

  // idle: deselected, clock parked low
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    hold_n_o = 1'b1;
  end

  // data set while low, read sampled at the rise; a floating line reads x
  task automatic bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      mosi_o = b[i];
      #15 sclk_o = 1'b1;
      rx_q = {rx_q[6:0], miso_oe_i ? miso_i : 1'bx};
      #15 sclk_o = 1'b0;
    end
  endtask

  task automatic sel();
    #7 cs_n_o = 1'b0;
    #20;
  endtask

  // select rises with the clock low; the released line is inverted
  task automatic desel();
    #5 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #300;
  endtask

  task automatic rd();
    bits(8'($urandom), 8);
    ->rx_ev;
  endtask

  // pause with clock low; clocks and noise during it must be ignored
  task automatic pause();
    #5 hold_n_o = 1'b0;
    repeat (3) begin
      mosi_o = ~mosi_o;
      #15 sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
    end
    #5 hold_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: test_serial_eeprom_command_unit.sv */
// self-checking bench for the serial eeprom command unit
`timescale 1ns/100ps
`default_nettype none
module test_serial_eeprom_command_unit
  import eeprom_cmd_pkg::*;
;
  logic mclk_i;
  logic rst_b_i;
  logic wp_n;
  logic sclk;
  logic cs_n;
  logic si;
  logic hold_n;
  logic so;
  logic so_oe;
  logic busy;
  int err_total;
  int checks;
  logic [7:0] exp_q[$];
  logic [7:0] buf_q[$];
  logic [7:0] old;
  logic [7:0] nw;
  logic [7:0] stv;

  // core clock; short write cycle keeps the run brief
  always #25 mclk_i = ~mclk_i;

  serial_eeprom_command_unit #(.WRITE_CYCLES(100)) u_dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .spi_clk_i(sclk),
    .chip_select_n_i(cs_n), .serial_in_i(si),
    .transfer_pause_n_i(hold_n), .write_protect_n_i(wp_n),
    .serial_out_o(so), .serial_out_oe_o(so_oe), .write_busy_o(busy));

  spi_host_model u_host (
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(si), .hold_n_o(hold_n),
    .miso_i(so), .miso_oe_i(so_oe));

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // each byte read is held against the oldest noted expectation
  always @(u_host.rx_ev) begin
    chk("read byte", u_host.rx_q, exp_q.pop_front());
  end

  task automatic wait_idle();
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 200) begin
      @(posedge mclk_i);
      i++;
    end
    if (i == 200) begin
      err_total++;
      complete_run();
    end
  endtask

  task automatic fill(input int n);
    buf_q.delete();
    repeat (n) buf_q.push_back(8'($urandom));
  endtask

  // n opcode bits, then x spare clocks
  task automatic cmd(input logic [7:0] op, input int n, input int x);
    u_host.sel();
    u_host.bits(op, n);
    u_host.bits(8'($urandom), x);
    u_host.desel();
  endtask

  task automatic sts(input logic [7:0] e);
    exp_q.push_back(e);
    exp_q.push_back(e);
    u_host.sel();
    u_host.bits(OP_STATUS_READ, 8);
    u_host.rd();
    u_host.rd();
    u_host.desel();
  endtask

  task automatic rdm(input logic [15:0] a, input int n);
    u_host.sel();
    u_host.bits(OP_ARRAY_READ, 8);
    u_host.bits(a[15:8], 8);
    u_host.pause();
    u_host.bits(a[7:0], 8);
    repeat (n) u_host.rd();
    u_host.desel();
  endtask

  // n bits of the last byte; b is the busy flag expected, -1 unknown
  task automatic wr(input logic [15:0] a, input int n, input int b);
    u_host.sel();
    u_host.bits(OP_ARRAY_WRITE, 8);
    u_host.bits(a[15:8], 8);
    u_host.bits(a[7:0], 8);
    foreach (buf_q[i]) u_host.bits(buf_q[i], i == buf_q.size() - 1 ? n : 8);
    u_host.desel();
    if (b >= 0) chk("busy", {7'h00, busy}, 8'(b));
    if (b == 1) begin
      sts(stv | 8'h03);
      exp_q.push_back(8'hxx);
      rdm(a, 1);
    end
    wait_idle();
  endtask

  task automatic stw(input logic [7:0] d, input int n, input int b);
    u_host.sel();
    u_host.bits(OP_STATUS_WRITE, 8);
    u_host.bits(d, n > 8 ? 8 : n);
    if (n > 8) u_host.bits(8'h00, n - 8);
    u_host.desel();
    chk("busy", {7'h00, busy}, 8'(b));
    wait_idle();
  endtask

  initial begin
    mclk_i = 1'b0;
    rst_b_i = 1'b0;
    wp_n = 1'b1;
    err_total = 0;
    checks = 0;
    stv = 8'h00;
    void'($urandom(32'hc75e));
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    sts(8'h00);
    cmd(OP_LATCH_SET, 6, 0);
    sts(8'h00);
    cmd(OP_LATCH_SET, 8, 4);
    sts(8'h02);
    cmd(OP_LATCH_CLEAR, 8, 0);
    sts(8'h00);
    $display("test latch done");
    cmd(OP_LATCH_SET, 8, 0);
    fill(3);
    old = buf_q[0];
    wr(16'h0c00, 8, 1);
    sts(8'h00);
    foreach (buf_q[i]) exp_q.push_back(buf_q[i]);
    rdm(16'h0c00, 3);
    buf_q[0] = ~old;
    wr(16'h0c00, 8, 0);
    cmd(OP_LATCH_SET, 8, 0);
    wr(16'h0c00, 7, 0);
    exp_q.push_back(old);
    rdm(16'h0c00, 1);
    sts(8'h02);
    $display("test write done");
    fill(33);
    wr(16'h0fe0, 8, 1);
    exp_q.push_back(buf_q[32]);
    for (int i = 1; i < 32; i++) exp_q.push_back(buf_q[i]);
    rdm(16'h0fe0, 32);
    $display("test page done");
    cmd(OP_LATCH_SET, 8, 0);
    stw(8'hf4, 9, 0);
    stw(8'hf4, 7, 0);
    sts(8'h02);
    stw(8'hf4, 8, 1);
    sts(8'h84);
    stv = 8'h84;
    @(posedge mclk_i);
    wp_n <= 1'b0;
    cmd(OP_LATCH_SET, 8, 0);
    stw(8'h00, 8, 0);
    sts(8'h86);
    fill(1);
    nw = buf_q[0];
    wr(16'h0bff, 8, 1);
    cmd(OP_LATCH_SET, 8, 0);
    buf_q[0] = ~old;
    wr(16'h0c00, 8, -1);
    exp_q.push_back(nw);
    exp_q.push_back(old);
    rdm(16'h0bff, 2);
    $display("test protect done");
    @(posedge mclk_i);
    wp_n <= 1'b1;
    cmd(OP_LATCH_SET, 8, 0);
    stw(8'h08, 8, 1);
    stv = 8'h08;
    cmd(OP_LATCH_SET, 8, 0);
    buf_q[0] = ~nw;
    wr(16'h0bff, 8, 1);
    exp_q.push_back(nw);
    rdm(16'h0bff, 1);
    @(posedge mclk_i);
    wp_n <= 1'b0;
    cmd(OP_LATCH_SET, 8, 0);
    stw(8'h00, 8, 1);
    sts(8'h00);
    $display("test status done");
    complete_run();
  end
endmodule

bind serial_eeprom_command_unit eeprom_cmd_checker #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_chk (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .write_busy_o(write_busy_o),
  .spi_clk_i(spi_clk_i), .chip_select_n_i(chip_select_n_i),
  .serial_in_i(serial_in_i), .transfer_pause_n_i(transfer_pause_n_i),
  .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o));
`default_nettype wire
